// file: test/testbench.sv
/*
  Testbench for the option latches and watchdog block.
  Assumes the design package is compiled first; shortened timeouts.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  // Bench-driven inputs
  logic aclk = 0, aresetn = 0, power_on_reset = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic stop_request = 0, wake_request = 0, wake_by_reset_pin = 0;
  logic reset_vector_fetch = 0, internal_reset = 0, monitor_mode = 0;
  logic break_state = 0, reset_pin_test_voltage = 0, irq_pin_test_voltage = 0;
  logic undervolt_reset_request = 0;
  logic [17:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 0;
  logic [7:0]  reset_vector_low = 8'hA5;
  // Design outputs
  logic awready, wready, bvalid, arready, rvalid, undervolt_reset_out;
  logic undervolt_powered, undervolt_stop_active, undervolt_mode_5v;
  logic oscillator_enable, pll_enable, clock_outputs_hold_low;
  logic serial_clock_from_bus, stop_mode_active, stop_exit;
  logic illegal_opcode_reset, reset_pin_low, watchdog_flag_set;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0]  r;
  int miscompares = 0, cmp_count = 0, n;

  option_latches_and_watchdog #(.LONG_TIMEOUT(18'h00100),
    .SHORT_TIMEOUT(18'h00040)) dut (.*);

  // Free-running crystal clock
  initial begin
    forever #20 aclk = ~aclk;
  end

  // Compare one value and count it
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // Bus write: both channels offered together, held until taken
  task automatic wr(input logic [17:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  // Bus read: returns data and response
  task automatic rd(input logic [17:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0; rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 1'b0;
  endtask : rd

  // Verdict in one place
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Hang guard, well past the expected run
  initial begin
    #800000;
    miscompares++;
    wrap_up();
  end

  // Options after power-up: cleared, written once, readable any time
  task automatic options_after_power_up;
    rd(18'h00078); chk("opt_b reset", 0, d);
    rd(18'h0007C); chk("opt_a reset", 0, d);
    wr(18'h00078, 32'h03); chk("opt_b bresp", 0, r);
    rd(18'h00078); chk("opt_b", 3, d);
    chk("baud", 1, serial_clock_from_bus);
    wr(18'h00078, 32'h00); rd(18'h00078); chk("opt_b lock", 3, d);
    rd(18'h00040); chk("unmapped", 2, r);
    rd(18'h3FFFC); chk("service rd", 32'hA5, d);
  endtask : options_after_power_up

  // Stop while stop is not enabled traps and does not stop
  task automatic illegal_stop;
    @(posedge aclk); stop_request <= 1'b1;
    @(posedge aclk); stop_request <= 1'b0;
    #1 chk("illegal op", 1, illegal_opcode_reset);
    chk("no stop", 0, stop_mode_active);
  endtask : illegal_stop

  // Undervoltage controls from option A
  task automatic undervolt_options;
    wr(18'h0007C, 32'h88); undervolt_reset_request <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("5v mode", 1, undervolt_mode_5v);
    chk("uv pwr", 1, undervolt_powered);
    chk("uv rst", 1, undervolt_reset_out);
    undervolt_reset_request <= 1'b0;
  endtask : undervolt_options

  // Short timeout from a cleared watchdog, pin pulse, then service
  task automatic watchdog_timeout;
    repeat (4200) @(posedge aclk);
    internal_reset <= 1'b1;
    @(posedge aclk); internal_reset <= 1'b0;
    n = 0;
    do begin @(posedge aclk); n++; end while (watchdog_flag_set !== 1'b1 && n < 200);
    chk("wd period", 32'h41, n);
    n = 0;
    while (reset_pin_low === 1'b1) begin n++; @(posedge aclk); end
    chk("pin low", 32, n);
    wr(18'h3FFFC, 32'h0); n = 0;
    do begin @(posedge aclk); n++; end while (watchdog_flag_set !== 1'b1 && n < 200);
    chk("wd early", 1, n > 40);
    chk("wd late", 1, n < 80);
  endtask : watchdog_timeout

  // System reset keeps the mode bit and its lock; disabled watchdog stays quiet
  task automatic system_reset_keeps_mode;
    @(posedge aclk); aresetn <= 1'b0;
    @(posedge aclk); aresetn <= 1'b1;
    rd(18'h0007C); chk("mode kept", 8, d);
    wr(18'h0007C, 32'h47);
    rd(18'h0007C); chk("mode lock", 32'h4F, d);
    n = 0;
    repeat (300) begin @(posedge aclk); if (watchdog_flag_set === 1'b1) n++; end
    chk("wd disabled", 0, n);
  endtask : system_reset_keeps_mode

  // Stop, check clock controls, wake and time the recovery
  task automatic stop_and_wake(input logic pin, input int exp, input logic osc);
    @(posedge aclk); stop_request <= 1'b1;
    @(posedge aclk); stop_request <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("stopped", 1, stop_mode_active);
    chk("osc run", osc, oscillator_enable);
    chk("clk low", !osc, clock_outputs_hold_low);
    chk("pll off", 0, pll_enable);
    chk("uv stop", 1, undervolt_stop_active);
    wake_by_reset_pin <= pin; wake_request <= 1'b1;
    @(posedge aclk); wake_request <= 1'b0;
    n = 0;
    do begin @(posedge aclk); n++; end while (stop_exit !== 1'b1 && n < 5000);
    chk("recovery", exp, n);
  endtask : stop_and_wake

  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1; power_on_reset <= 1'b0;
    options_after_power_up();
    illegal_stop();
    undervolt_options();
    watchdog_timeout();
    system_reset_keeps_mode();
    stop_and_wake(1'b0, int'(option_watchdog_pkg::SHORT_RECOVERY_CYCLES) + 1, 1'b0);
    wr(18'h00078, 32'h02);
    stop_and_wake(1'b1, int'(option_watchdog_pkg::LONG_RECOVERY_CYCLES) + 1, 1'b1);
    wrap_up();
  end
endmodule : testbench

`default_nettype wire

// file: verilog/option_latches_and_watchdog.sv
/*
  Write-once option latches with the watchdog, stop sequencing and the
  option-driven control outputs, behind an AXI4-Lite slave.
  Assumes aclk is the crystal clock, aresetn is the system reset and
  power_on_reset marks power-up; event inputs are one-cycle pulses on aclk.
*/
// Our own choice: register access over AXI4-Lite.
// Notes on behaviour
// - Each option register takes one write per reset
// - Reset clears options; mode bit only by power-on
// - Option registers readable at any time
// - Mode bit writable once per power-on reset
// - Oscillator runs in stop when bit set
// - Baud source: bus clock or oscillator clock
// - Rate bit selects short or long timeout
// - Monitor runs in stop when enabled, powered
// - Reset-disable bit blocks monitor resets
// - Power-disable bit powers down the monitor
// - Mode bit selects 5V or 3V trip points
// - Stop recovery 32 or 4096; pin wake long
// - Disabled stop gives illegal-opcode reset
// - Disable bit stops all watchdog resets
// - Six-bit counter after twelve-bit prescaler
// - Counter overflow raises a reset
// - Service write clears counter, upper prescaler
// - Watchdog reset: pin low 32 cycles, flag
// - Test voltage in monitor, or reset-pin test voltage in break, halts watchdog
// - Internal reset clears all; stop, fetch prescaler
// - Power-on clears prescaler after 4096 cycles
// - Stop without oscillator holds clock outputs low
`timescale 1ns/100ps
`default_nettype none

module option_latches_and_watchdog #(
  parameter logic [17:0] LONG_TIMEOUT  = 18'h3FFF0,  // 2^18 - 2^4 cycles
  parameter logic [17:0] SHORT_TIMEOUT = 18'h01FF0   // 2^13 - 2^4 cycles
) (
  // Clock and reset
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic                                  power_on_reset,
  // AXI4-Lite write address and data
  input  wire logic [option_watchdog_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                                  awvalid,
  output var  logic                                  awready,
  input  wire logic [31:0]                           wdata,
  input  wire logic [3:0]                            wstrb,
  input  wire logic                                  wvalid,
  output var  logic                                  wready,
  // AXI4-Lite write response
  output var  logic [1:0]                            bresp,
  output var  logic                                  bvalid,
  input  wire logic                                  bready,
  // AXI4-Lite read
  input  wire logic [option_watchdog_pkg::ADDR_W-1:0] araddr,
  input  wire logic                                  arvalid,
  output var  logic                                  arready,
  output var  logic [31:0]                           rdata,
  output var  logic [1:0]                            rresp,
  output var  logic                                  rvalid,
  input  wire logic                                  rready,
  // CPU events
  input  wire logic                                  stop_request,
  input  wire logic                                  wake_request,
  input  wire logic                                  wake_by_reset_pin,
  input  wire logic                                  reset_vector_fetch,
  input  wire logic                                  internal_reset,
  input  wire logic [7:0]                            reset_vector_low,
  // Test conditions
  input  wire logic                                  monitor_mode,
  input  wire logic                                  break_state,
  input  wire logic                                  reset_pin_test_voltage,
  input  wire logic                                  irq_pin_test_voltage,
  // Undervoltage monitor
  input  wire logic                                  undervolt_reset_request,
  output var  logic                                  undervolt_reset_out,
  output var  logic                                  undervolt_powered,
  output var  logic                                  undervolt_stop_active,
  output var  logic                                  undervolt_mode_5v,
  // Clock control
  output var  logic                                  oscillator_enable,
  output var  logic                                  pll_enable,
  output var  logic                                  clock_outputs_hold_low,
  output var  logic                                  serial_clock_from_bus,
  // Stop and reset outputs
  output var  logic                                  stop_mode_active,
  output var  logic                                  stop_exit,
  output var  logic                                  illegal_opcode_reset,
  output var  logic                                  reset_pin_low,
  output var  logic                                  watchdog_flag_set
);

  // Option storage and locks
  logic [7:0] system_option_a;   // Bit of mode held apart below
  logic [7:0] system_option_b;
  logic       lock_a;            // First write to option A taken
  logic       lock_b;            // First write to option B taken
  logic       mode_bit;          // Undervoltage mode, kept over system resets
  logic       mode_lock;         // Mode write used since power-on

  // Watchdog state
  logic [option_watchdog_pkg::PRESCALER_W-1:0] prescaler;
  logic [option_watchdog_pkg::COUNTER_W-1:0]   wd_counter;
  logic [12:0]                                 por_count;    // Power-on settle count
  logic [5:0]                                  pulse_count;  // Reset pin low length
  logic [12:0]                                 rec_count;    // Stop recovery length
  option_watchdog_pkg::stop_state_t            stop_state;

  // Bus holding registers
  logic                                     aw_held;
  logic                                     w_held;
  logic [option_watchdog_pkg::ADDR_W-1:0]   aw_addr;
  logic [7:0]                               w_byte;
  logic                                     w_lane0;

  // Address decode shared by both paths
  function automatic logic [1:0] reg_sel(input logic [option_watchdog_pkg::ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[option_watchdog_pkg::ADDR_W-1:2];
    if (addr[1:0] != 2'h0) begin
      reg_sel = option_watchdog_pkg::SEL_NONE;
    end else if (idx == option_watchdog_pkg::OPTION_B_INDEX) begin
      reg_sel = option_watchdog_pkg::SEL_OPTION_B;
    end else if (idx == option_watchdog_pkg::OPTION_A_INDEX) begin
      reg_sel = option_watchdog_pkg::SEL_OPTION_A;
    end else if (idx == option_watchdog_pkg::SERVICE_INDEX) begin
      reg_sel = option_watchdog_pkg::SEL_SERVICE;
    end else begin
      reg_sel = option_watchdog_pkg::SEL_NONE;
    end
  endfunction : reg_sel

  // Pin conditions pass three flops; the filtered level moves when stages one and two agree
  wire  [1:0] pin_level;  // Filtered levels, each bit driven by the level flop of its own filter
  wire  [1:0] pin_raw = {irq_pin_test_voltage, reset_pin_test_voltage};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      logic [2:0] stages;  // Stage 0 meets the pin
      logic       level;   // Accepted level of this pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stages <= 3'h0;
          level  <= 1'b0;
        end else begin
          stages <= {stages[1:0], pin_raw[gi]};
          if (stages[1] == stages[2]) begin
            level <= stages[2];
          end
        end
      end
      assign pin_level[gi] = level;
    end
  endgenerate
  wire rst_tv = pin_level[0];
  wire irq_tv = pin_level[1];

  // Option field views
  wire osc_run_in_stop         = system_option_b[option_watchdog_pkg::OSC_RUN_IN_STOP_BIT];
  wire serial_baud_source      = system_option_b[option_watchdog_pkg::SERIAL_BAUD_SOURCE_BIT];
  wire watchdog_rate_sel       = system_option_a[option_watchdog_pkg::WATCHDOG_RATE_SEL_BIT];
  wire undervolt_in_stop       = system_option_a[option_watchdog_pkg::UNDERVOLT_IN_STOP_BIT];
  wire undervolt_reset_disable = system_option_a[option_watchdog_pkg::UNDERVOLT_RESET_DISABLE_BIT];
  wire undervolt_power_disable = system_option_a[option_watchdog_pkg::UNDERVOLT_POWER_DISABLE_BIT];
  wire short_stop_recovery     = system_option_a[option_watchdog_pkg::SHORT_STOP_RECOVERY_BIT];
  wire stop_enable             = system_option_a[option_watchdog_pkg::STOP_ENABLE_BIT];
  wire watchdog_disable        = system_option_a[option_watchdog_pkg::WATCHDOG_DISABLE_BIT];

  // Read view puts the mode bit back into option A
  wire [7:0] option_a_view = system_option_a |
      ({7'h00, mode_bit} << option_watchdog_pkg::UNDERVOLT_VOLTAGE_MODE_BIT);

  // Write path decode
  wire       do_write   = aw_held && w_held && !bvalid;
  wire [1:0] wr_sel     = reg_sel(aw_addr);
  wire       wr_a       = do_write && w_lane0 && (wr_sel == option_watchdog_pkg::SEL_OPTION_A);
  wire       wr_b       = do_write && w_lane0 && (wr_sel == option_watchdog_pkg::SEL_OPTION_B);
  wire       service    = do_write && (wr_sel == option_watchdog_pkg::SEL_SERVICE);
  wire [1:0] next_bresp = (wr_sel == option_watchdog_pkg::SEL_NONE) ?
                          option_watchdog_pkg::RESP_SLVERR : option_watchdog_pkg::RESP_OKAY;
  wire       aw_take    = awvalid && awready;
  wire       w_take     = wvalid && wready;
  wire       next_aw_held = do_write ? 1'b0 : (aw_held || aw_take);
  wire       next_w_held  = do_write ? 1'b0 : (w_held || w_take);
  wire       next_bvalid  = do_write ? 1'b1 : (bvalid && !bready);

  // Read path decode
  wire       ar_take    = arvalid && arready;
  wire [1:0] rd_sel     = reg_sel(araddr);
  wire [7:0] rd_byte    = (rd_sel == option_watchdog_pkg::SEL_OPTION_A) ? option_a_view :
                          (rd_sel == option_watchdog_pkg::SEL_OPTION_B) ? system_option_b :
                          (rd_sel == option_watchdog_pkg::SEL_SERVICE)  ? reset_vector_low :
                          8'h00;
  wire       next_rvalid = ar_take ? 1'b1 : (rvalid && !rready);

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= option_watchdog_pkg::RESP_OKAY;
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      bvalid  <= next_bvalid;
      awready <= !next_aw_held && !next_bvalid;
      wready  <= !next_w_held && !next_bvalid;
      if (aw_take) begin
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_byte  <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end
      if (do_write) begin
        bresp <= next_bresp;
      end
    end
  end

  // Read channel; contents returned whether or not a write was taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      arready <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= option_watchdog_pkg::RESP_OKAY;
    end else begin
      rvalid  <= next_rvalid;
      arready <= !next_rvalid;
      if (ar_take) begin
        rdata <= {24'h000000, rd_byte};
        rresp <= (rd_sel == option_watchdog_pkg::SEL_NONE) ?
                 option_watchdog_pkg::RESP_SLVERR : option_watchdog_pkg::RESP_OKAY;
      end
    end
  end

  // Option latches: first write after reset sticks, later ones are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_option_a <= option_watchdog_pkg::OPTION_RESET;
      system_option_b <= option_watchdog_pkg::OPTION_RESET;
      lock_a          <= 1'b0;
      lock_b          <= 1'b0;
    end else begin
      if (wr_a && !lock_a) begin
        system_option_a <= w_byte & ~(8'h01 << option_watchdog_pkg::UNDERVOLT_VOLTAGE_MODE_BIT);
        lock_a          <= 1'b1;
      end
      if (wr_b && !lock_b) begin
        system_option_b <= w_byte;
        lock_b          <= 1'b1;
      end
    end
  end

  // Mode bit: cleared and reopened by power-on reset only
  always_ff @(posedge aclk) begin
    if (power_on_reset) begin
      mode_bit  <= 1'b0;
      mode_lock <= 1'b0;
    end else if (aresetn && wr_a && !mode_lock) begin
      mode_bit  <= w_byte[option_watchdog_pkg::UNDERVOLT_VOLTAGE_MODE_BIT];
      mode_lock <= 1'b1;
    end
  end

  // Stop sequencing and recovery delay
  wire stop_take   = stop_request && (stop_state == option_watchdog_pkg::RUNNING);
  wire stop_enter  = stop_take && stop_enable;
  wire stop_illegal = stop_take && !stop_enable;
  wire [12:0] rec_len = (short_stop_recovery && !wake_by_reset_pin) ?
                        option_watchdog_pkg::SHORT_RECOVERY_CYCLES :
                        option_watchdog_pkg::LONG_RECOVERY_CYCLES;
  wire rec_done = (stop_state == option_watchdog_pkg::RECOVERING) && (rec_count == 13'h0000);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_state <= option_watchdog_pkg::RUNNING;
      rec_count  <= 13'h0000;
    end else begin
      unique case (stop_state)
        option_watchdog_pkg::RUNNING: begin
          if (stop_enter) begin
            stop_state <= option_watchdog_pkg::STOPPED;
          end
        end
        option_watchdog_pkg::STOPPED: begin
          if (wake_request) begin
            stop_state <= option_watchdog_pkg::RECOVERING;
            rec_count  <= rec_len - 13'h0001;
          end
        end
        option_watchdog_pkg::RECOVERING: begin
          if (rec_done) begin
            stop_state <= option_watchdog_pkg::RUNNING;
          end else begin
            rec_count <= rec_count - 13'h0001;
          end
        end
      endcase
    end
  end

  // Watchdog run conditions and overflow detection
  wire stopped_now = stop_state == option_watchdog_pkg::STOPPED;
  wire test_block  = (monitor_mode && (rst_tv || irq_tv)) || (break_state && rst_tv);
  wire wd_run      = !watchdog_disable && !test_block &&
                     (stop_state == option_watchdog_pkg::RUNNING) && (por_count == 13'h0000);
  wire [17:0] wd_chain = watchdog_rate_sel ?
      {5'h00, wd_counter, prescaler[option_watchdog_pkg::SHORT_TAP_W-1:0]} :
      {wd_counter, prescaler};
  wire [17:0] wd_limit = watchdog_rate_sel ? SHORT_TIMEOUT : LONG_TIMEOUT;
  wire wd_overflow = wd_run && (wd_chain == wd_limit - 18'h00001);
  wire tap_carry   = watchdog_rate_sel ?
      (&prescaler[option_watchdog_pkg::SHORT_TAP_W-1:0]) : (&prescaler);
  wire por_done    = por_count == 13'h0001;

  // Prescaler and counter
  always_ff @(posedge aclk) begin
    if (!aresetn || internal_reset || wd_overflow) begin
      prescaler  <= '0;
      wd_counter <= '0;
    end else if (service) begin
      wd_counter <= '0;
      prescaler[option_watchdog_pkg::PRESCALER_W-1:option_watchdog_pkg::SERVICE_CLEAR_LSB] <= '0;
    end else if (stop_enter || reset_vector_fetch || por_done) begin
      prescaler <= '0;
    end else if (wd_run) begin
      prescaler <= prescaler + 12'h001;
      if (tap_carry) begin
        wd_counter <= wd_counter + 6'h01;
      end
    end
  end

  // Power-on settle counter
  always_ff @(posedge aclk) begin
    if (power_on_reset) begin
      por_count <= option_watchdog_pkg::POR_CLEAR_CYCLES;
    end else if (por_count != 13'h0000) begin
      por_count <= por_count - 13'h0001;
    end
  end

  // Reset pin pulse length
  wire [5:0] next_pulse_count = wd_overflow ? option_watchdog_pkg::RESET_PULSE_CYCLES :
                                (pulse_count != 6'h00) ? pulse_count - 6'h01 : 6'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_count <= 6'h00;
    end else begin
      pulse_count <= next_pulse_count;
    end
  end

  // Registered control outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      undervolt_reset_out    <= 1'b0;
      undervolt_powered      <= 1'b1;
      undervolt_stop_active  <= 1'b0;
      undervolt_mode_5v      <= 1'b0;
      oscillator_enable      <= 1'b1;
      pll_enable             <= 1'b1;
      clock_outputs_hold_low <= 1'b0;
      serial_clock_from_bus  <= 1'b0;
      stop_mode_active       <= 1'b0;
      stop_exit              <= 1'b0;
      illegal_opcode_reset   <= 1'b0;
      reset_pin_low          <= 1'b0;
      watchdog_flag_set      <= 1'b0;
    end else begin
      undervolt_reset_out    <= undervolt_reset_request && !undervolt_reset_disable;
      undervolt_powered      <= !undervolt_power_disable;
      undervolt_stop_active  <= !undervolt_power_disable && undervolt_in_stop && stopped_now;
      undervolt_mode_5v      <= mode_bit;
      oscillator_enable      <= !stopped_now || osc_run_in_stop;
      pll_enable             <= !stopped_now;
      clock_outputs_hold_low <= stopped_now && !osc_run_in_stop;
      serial_clock_from_bus  <= serial_baud_source;
      stop_mode_active       <= stopped_now;
      stop_exit              <= rec_done;
      illegal_opcode_reset   <= stop_illegal;
      reset_pin_low          <= next_pulse_count != 6'h00;
      watchdog_flag_set      <= wd_overflow;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence short_wake_s;
    stopped_now && wake_request && short_stop_recovery && !wake_by_reset_pin;
  endsequence
  // Eight cycles with no exit pulse
  sequence quiet_eight_s;
    !stop_exit [*8];
  endsequence
  // Thirty-two quiet cycles, then the exit pulse
  sequence short_exit_s;
    quiet_eight_s ##1 quiet_eight_s ##1 quiet_eight_s ##1 quiet_eight_s ##1 stop_exit;
  endsequence

  option_lock_a: assert property (lock_a && $past(lock_a) |-> system_option_a == $past(system_option_a))
    else $error("locked option A changed");
  option_read_a: assert property (ar_take && rd_sel == option_watchdog_pkg::SEL_OPTION_A |=> rdata[7:0] == $past(option_a_view))
    else $error("option A read returned wrong data");
  mode_hold_a: assert property (mode_lock && $past(mode_lock) && !power_on_reset |-> mode_bit == $past(mode_bit))
    else $error("locked mode bit changed");
  short_recovery_a: assert property (short_wake_s |=> short_exit_s)
    else $error("short stop recovery length wrong");
  long_recovery_a: assert property (stopped_now && wake_request && (!short_stop_recovery || wake_by_reset_pin) |=> rec_count == 13'h0FFF)
    else $error("long stop recovery not loaded");
  illegal_stop_a: assert property (stop_take && !stop_enable |=> illegal_opcode_reset && stop_state == option_watchdog_pkg::RUNNING)
    else $error("disabled stop not trapped");
  wd_disable_a: assert property (watchdog_disable || test_block |=> !watchdog_flag_set)
    else $error("watchdog fired while disabled");
  pin_pulse_a: assert property ($fell(reset_pin_low) && $past(aresetn) |-> $past(wd_overflow, 33))
    else $error("reset pin pulse length wrong");
  service_clear_a: assert property (service && !internal_reset && !wd_overflow |=> wd_counter == 6'h00 && prescaler[11:4] == 8'h00)
    else $error("service did not clear watchdog");
  flag_pulse_a: assert property (wd_overflow |=> watchdog_flag_set && reset_pin_low)
    else $error("overflow gave no reset");

endmodule : option_latches_and_watchdog

`default_nettype wire

// file: verilog/option_watchdog_pkg.sv
/*
  Shared constants for the option latches and watchdog block:
  register indices, field positions, reset values, cycle counts, states.
  Assumes one crystal clock domain and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package option_watchdog_pkg;

  // Bus geometry
  localparam int          ADDR_W         = 18;        // Byte address width
  localparam logic [15:0] OPTION_B_INDEX = 16'h001E;  // Word index of system_option_b
  localparam logic [15:0] OPTION_A_INDEX = 16'h001F;  // Word index of system_option_a
  localparam logic [15:0] SERVICE_INDEX  = 16'hFFFF;  // Word index of watchdog_service
  localparam logic [1:0]  RESP_OKAY      = 2'h0;      // Normal answer
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;      // Unmapped address

  // Register select codes
  localparam logic [1:0] SEL_NONE     = 2'h0;
  localparam logic [1:0] SEL_OPTION_B = 2'h1;
  localparam logic [1:0] SEL_OPTION_A = 2'h2;
  localparam logic [1:0] SEL_SERVICE  = 2'h3;

  // Field positions in system_option_b
  localparam int OSC_RUN_IN_STOP_BIT    = 1;
  localparam int SERIAL_BAUD_SOURCE_BIT = 0;

  // Field positions in system_option_a
  localparam int WATCHDOG_RATE_SEL_BIT       = 7;
  localparam int UNDERVOLT_IN_STOP_BIT       = 6;
  localparam int UNDERVOLT_RESET_DISABLE_BIT = 5;
  localparam int UNDERVOLT_POWER_DISABLE_BIT = 4;
  localparam int UNDERVOLT_VOLTAGE_MODE_BIT  = 3;
  localparam int SHORT_STOP_RECOVERY_BIT     = 2;
  localparam int STOP_ENABLE_BIT             = 1;
  localparam int WATCHDOG_DISABLE_BIT        = 0;

  // Reset values
  localparam logic [7:0] OPTION_RESET = 8'h00;

  // Counts in crystal-clock cycles
  localparam logic [12:0] SHORT_RECOVERY_CYCLES = 13'h0020;  // 32 cycles
  localparam logic [12:0] LONG_RECOVERY_CYCLES  = 13'h1000;  // 4096 cycles
  localparam logic [12:0] POR_CLEAR_CYCLES      = 13'h1000;  // 4096 cycles
  localparam logic [5:0]  RESET_PULSE_CYCLES    = 6'h20;     // 32 cycles

  // Watchdog structure
  localparam int PRESCALER_W       = 12;  // Prescaler stages
  localparam int COUNTER_W         = 6;   // Watchdog counter stages
  localparam int SHORT_TAP_W       = 7;   // Prescaler stages used at the fast rate
  localparam int SERVICE_CLEAR_LSB = 4;   // Lowest prescaler stage cleared on service

  // Stop-mode sequencing
  typedef enum logic [1:0] {RUNNING, STOPPED, RECOVERING} stop_state_t;

endpackage : option_watchdog_pkg

`default_nettype wire
